// ===== inc/upes_consts.vh
// register offsets, field positions, reset values and timing counts for the
// event status register block.
// assumes an 8-bit register access port with a 6-bit address.
`ifndef UPES_CONSTS_VH
`define UPES_CONSTS_VH

`define UPES_ADDR_FALL_EN      6'h10
`define UPES_ADDR_FALL_SET     6'h11
`define UPES_ADDR_FALL_CLR     6'h12
`define UPES_ADDR_STATUS       6'h13
`define UPES_ADDR_LATCH        6'h14
`define UPES_ADDR_LINE_MON     6'h15
`define UPES_ADDR_TEST         6'h16
`define UPES_ADDR_TEST_SET     6'h17
`define UPES_ADDR_TEST_CLR     6'h18
`define UPES_ADDR_EXTRA_EN     6'h3d

`define UPES_BIT_HOST_DETACH   0
`define UPES_BIT_BUS_PWR       1
`define UPES_BIT_SESS_VALID    2
`define UPES_BIT_SESS_END      3
`define UPES_BIT_ID_GND        4

`define UPES_XBIT_BSESS_RISE   2
`define UPES_XBIT_BSESS_FALL   3
`define UPES_XBIT_ID_RES       4
`define UPES_XBIT_ID_OPEN      5
`define UPES_XBIT_SUPPLY       6

`define UPES_FALL_EN_RESET     5'h1f
`define UPES_RISE_EN_RESET     5'h1f
`define UPES_TEST_RESET        8'h00
`define UPES_EXTRA_EN_RESET    8'h00
`define UPES_EXTRA_WR_MASK     8'h7f

`define UPES_CLK_MHZ           125
`define UPES_ID_SETTLE_MS      50
`define UPES_ID_SETTLE_CYCLES  (`UPES_ID_SETTLE_MS * 1000 * `UPES_CLK_MHZ)

`endif

// ===== hw/upes_edge_det.v
// change detector: registers a vector and flags rising and falling edges.
// assumes inputs already synchronous to core_clk_i.
`timescale 1ns/100ps
`default_nettype none
module upes_edge_det #(
  parameter W = 5
) (
  input wire core_clk_i,
  input wire rstn_i,
  input wire [W-1:0] sig_i,
  input wire [W-1:0] reset_val_i,
  output wire [W-1:0] rise_o,
  output wire [W-1:0] fall_o
);
  reg [W-1:0] prev;
  // reset load of prev is done synchronously, so a live value is legal here
  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      prev <= reset_val_i;
    end else begin
      prev <= sig_i;
    end
  end
  assign rise_o = sig_i & ~prev;
  assign fall_o = ~sig_i & prev;
endmodule
`default_nettype wire

// ===== hw/upes_settle_timer.v
// settle timer: counts down after the id sense enable rises; reports when
// the id-grounded signal may be trusted.
// assumes sense_en_i synchronous to core_clk_i.
`timescale 1ns/100ps
`default_nettype none
module upes_settle_timer #(
  parameter [31:0] CYCLES = 32'd6250000
) (
  input wire core_clk_i,
  input wire rstn_i,
  input wire sense_en_i,
  output wire settled_o
);
  reg [31:0] count;
  reg en_d;
  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      count <= 32'h0;
      en_d <= 1'b0;
    end else begin
      en_d <= sense_en_i;
      if (!sense_en_i) begin
        count <= 32'h0;
      end else if (!en_d) begin
        count <= CYCLES;
      end else if (count != 32'h0) begin
        count <= count - 32'h1;
      end
    end
  end
  assign settled_o = sense_en_i & en_d & (count == 32'h0);
endmodule
`default_nettype wire

// ===== hw/upes_event_regs.v
// event enable, status, latch, line monitor and scratch registers of the
// transceiver, with debug rx cmd event requests.
// assumes the link register port gives one-cycle read and write strobes,
// all inputs synchronous to core_clk_i, and rx cmd framing done elsewhere.
`timescale 1ns/100ps
`default_nettype none
`include "upes_consts.vh"

// Notes on behaviour
// - falling edge on each of five sources raises an event; enables reset to 1
// - id-grounded falls masked while id sense off and 50 ms after it turns on
// - host-detach falls only count in host mode, both pulldowns on
// - 0x11 reads fall enables; written ones set bits
// - 0x12 reads fall enables; written ones clear bits
// - 0x13 shows live source values in bits 4..0, upper bits zero
// - id-grounded status frozen while id sense off and 50 ms after
// - host-detach status forced to zero in low power mode
// - latch at 0x14 sets on any unmasked source change
// - reading the latch clears it entirely
// - entering serial or carkit mode clears the latch
// - a latch read coinciding with an event reports it and leaves bit unset
// - host-detach status and latch reset to the detach level
// - 0x15 shows line receivers, plus line bit 0, minus line bit 1
// - line state codes: 0 se0/squelch, 1 k/j, 2 j/k, 3 se1
// - scratch byte at 0x16 resets to zero and affects nothing else
// - 0x17 sets and 0x18 clears scratch bits with written ones
// - supply monitor change sends rx cmd when its enable is set
// - id open change sends rx cmd when its enable is set
// - any id resistor comparator change sends rx cmd when enabled
// - b-session fall sends alt rx cmd when enabled; resets off
// - b-session rise sends alt rx cmd when enabled; resets off
module upes_event_regs #(
  parameter [31:0] ID_SETTLE_CYCLES = `UPES_ID_SETTLE_CYCLES
) (
  input wire core_clk_i,
  input wire rstn_i,
  input wire [5:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  output reg reg_rvalid_o,
  input wire id_grounded_i,
  input wire session_end_i,
  input wire session_valid_i,
  input wire bus_power_valid_i,
  input wire host_detach_i,
  input wire [4:0] rise_en_i,
  input wire id_sense_enable_i,
  input wire pos_line_pulldown_en_i,
  input wire neg_line_pulldown_en_i,
  input wire low_power_i,
  input wire serial_mode_i,
  input wire carkit_mode_i,
  input wire [1:0] line_state_i,
  input wire supply_monitor_ok_i,
  input wire id_open_flag_i,
  input wire id_resistor_cmp_a_i,
  input wire id_resistor_cmp_b_i,
  input wire id_resistor_cmp_c_i,
  input wire b_session_valid_i,
  output wire [4:0] fall_event_enable_o,
  output reg event_req_o,
  output reg alt_event_req_o
);
  // ************************************************************
  // source conditioning
  // ************************************************************
  wire id_settled;
  wire host_mode;
  wire [4:0] src_raw;
  wire [4:0] src_rst;
  wire [4:0] src_rise;
  wire [4:0] src_fall;
  reg id_gnd_held;
  reg [4:0] fall_en;
  reg [4:0] latch;
  reg [7:0] test_byte;
  reg [7:0] extra_en;
  reg lp_d;
  reg ser_d;
  reg car_d;

  upes_settle_timer #(
    .CYCLES(ID_SETTLE_CYCLES)
  ) u_settle (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .sense_en_i(id_sense_enable_i),
    .settled_o(id_settled)
  );

  assign host_mode = pos_line_pulldown_en_i & neg_line_pulldown_en_i;

  // id status only follows the pin once sensing has settled
  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      id_gnd_held <= 1'b0;
    end else if (id_settled) begin
      id_gnd_held <= id_grounded_i;
    end
  end

  assign src_raw[`UPES_BIT_ID_GND] = id_gnd_held;
  assign src_raw[`UPES_BIT_SESS_END] = session_end_i;
  assign src_raw[`UPES_BIT_SESS_VALID] = session_valid_i;
  assign src_raw[`UPES_BIT_BUS_PWR] = bus_power_valid_i;
  // low power forces the detach status low
  assign src_raw[`UPES_BIT_HOST_DETACH] =
    host_detach_i & ~low_power_i;

  // only the detach bit starts from zero, so a detached host at release
  // shows up as a rise and lands in the latch: the detach reset level.
  // the other sources start from their live level, so a source already
  // high at release raises no false event
  assign src_rst = {src_raw[4:1], 1'b0};

  upes_edge_det #(
    .W(5)
  ) u_src_edges (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .sig_i(src_raw),
    .reset_val_i(src_rst),
    .rise_o(src_rise),
    .fall_o(src_fall)
  );

  // ************************************************************
  // event masking
  // ************************************************************
  function [4:0] upes_mode_mask;
    input settled;
    input hmode;
    begin
      upes_mode_mask = 5'h1f;
      upes_mode_mask[`UPES_BIT_ID_GND] = settled;
      upes_mode_mask[`UPES_BIT_HOST_DETACH] = hmode;
    end
  endfunction

  wire [4:0] mode_mask;
  wire [4:0] fall_hit;
  wire [4:0] rise_hit;
  wire [4:0] event_hit;
  assign mode_mask = upes_mode_mask(id_settled, host_mode);
  assign fall_hit = src_fall & fall_en & mode_mask;
  assign rise_hit = src_rise & rise_en_i & mode_mask;
  assign event_hit = fall_hit | rise_hit;

  // ************************************************************
  // register decode
  // ************************************************************
  // one address compare shared by every write strobe and the latch read
  function upes_at;
    input [5:0] addr;
    input [5:0] target;
    begin
      upes_at = (addr == target);
    end
  endfunction

  wire wr_fall_set;
  wire wr_fall_clr;
  wire wr_fall;
  wire wr_test;
  wire wr_test_set;
  wire wr_test_clr;
  wire wr_extra;
  wire rd_latch;
  wire lp_entry;
  wire mode_entry;
  assign wr_fall = reg_wr_i & upes_at(reg_addr_i, `UPES_ADDR_FALL_EN);
  assign wr_fall_set = reg_wr_i & upes_at(reg_addr_i, `UPES_ADDR_FALL_SET);
  assign wr_fall_clr = reg_wr_i & upes_at(reg_addr_i, `UPES_ADDR_FALL_CLR);
  assign wr_test = reg_wr_i & upes_at(reg_addr_i, `UPES_ADDR_TEST);
  assign wr_test_set = reg_wr_i & upes_at(reg_addr_i, `UPES_ADDR_TEST_SET);
  assign wr_test_clr = reg_wr_i & upes_at(reg_addr_i, `UPES_ADDR_TEST_CLR);
  assign wr_extra = reg_wr_i & upes_at(reg_addr_i, `UPES_ADDR_EXTRA_EN);
  assign rd_latch = reg_rd_i & upes_at(reg_addr_i, `UPES_ADDR_LATCH);
  assign lp_entry = low_power_i & ~lp_d;
  assign mode_entry = (serial_mode_i & ~ser_d) | (carkit_mode_i & ~car_d);

  // entry is the rising edge of each mode level, so a link that stays in a
  // mode clears the latch once and then lets events collect again
  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      lp_d <= 1'b0;
      ser_d <= 1'b0;
      car_d <= 1'b0;
    end else begin
      lp_d <= low_power_i;
      ser_d <= serial_mode_i;
      car_d <= carkit_mode_i;
    end
  end

  // ************************************************************
  // writable registers
  // ************************************************************
  // the plain register and its two aliases share one state; the link
  // gives at most one strobe per cycle, so the priority order is moot
  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      fall_en <= `UPES_FALL_EN_RESET;
    end else if (wr_fall) begin
      fall_en <= reg_wdata_i[4:0];
    end else if (wr_fall_set) begin
      fall_en <= fall_en | reg_wdata_i[4:0];
    end else if (wr_fall_clr) begin
      fall_en <= fall_en & ~reg_wdata_i[4:0];
    end
  end
  assign fall_event_enable_o = fall_en;

  // scratch is touched by nothing but its own three addresses
  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      test_byte <= `UPES_TEST_RESET;
    end else if (wr_test) begin
      test_byte <= reg_wdata_i;
    end else if (wr_test_set) begin
      test_byte <= test_byte | reg_wdata_i;
    end else if (wr_test_clr) begin
      test_byte <= test_byte & ~reg_wdata_i;
    end
  end

  // bit 7 is the link's to keep at zero; masked anyway for safety
  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      extra_en <= `UPES_EXTRA_EN_RESET;
    end else if (wr_extra) begin
      extra_en <= reg_wdata_i & `UPES_EXTRA_WR_MASK;
    end
  end

  // ************************************************************
  // event latch
  // ************************************************************
  // a read returns the events of this very cycle and drops them, so no
  // event is lost between read data and the clear
  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      latch <= 5'h00;
    end else if (lp_entry) begin
      latch <= 5'h00;
    end else if (mode_entry) begin
      latch <= 5'h00;
    end else if (rd_latch) begin
      latch <= 5'h00;
    end else begin
      latch <= latch | event_hit;
    end
  end

  // ************************************************************
  // read data
  // ************************************************************
  reg [7:0] next_rdata;
  always @* begin
    next_rdata = 8'h00;
    if (reg_addr_i == `UPES_ADDR_FALL_EN) begin
      next_rdata = {3'h0, fall_en};
    end else if (reg_addr_i == `UPES_ADDR_FALL_SET) begin
      next_rdata = {3'h0, fall_en};
    end else if (reg_addr_i == `UPES_ADDR_FALL_CLR) begin
      next_rdata = {3'h0, fall_en};
    end else if (reg_addr_i == `UPES_ADDR_STATUS) begin
      next_rdata = {3'h0, src_raw};
    end else if (reg_addr_i == `UPES_ADDR_LATCH) begin
      next_rdata = {3'h0, latch | event_hit};
    end else if (reg_addr_i == `UPES_ADDR_LINE_MON) begin
      // raw receiver pair; decoding per speed is the link's job
      next_rdata = {6'h00, line_state_i};
    end else if (reg_addr_i == `UPES_ADDR_TEST) begin
      next_rdata = test_byte;
    end else if (reg_addr_i == `UPES_ADDR_TEST_SET) begin
      next_rdata = test_byte;
    end else if (reg_addr_i == `UPES_ADDR_TEST_CLR) begin
      next_rdata = test_byte;
    end else if (reg_addr_i == `UPES_ADDR_EXTRA_EN) begin
      next_rdata = extra_en;
    end
  end

  // read data is held between reads; only rvalid marks the fresh byte
  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= next_rdata;
      end
    end
  end

  // ************************************************************
  // debug rx cmd requests
  // ************************************************************
  wire [5:0] dbg_sig;
  wire [5:0] dbg_rise;
  wire [5:0] dbg_fall;
  wire [5:0] dbg_chg;
  assign dbg_sig = {b_session_valid_i, supply_monitor_ok_i, id_open_flag_i,
                    id_resistor_cmp_c_i, id_resistor_cmp_b_i,
                    id_resistor_cmp_a_i};

  upes_edge_det #(
    .W(6)
  ) u_dbg_edges (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .sig_i(dbg_sig),
    .reset_val_i(dbg_sig),
    .rise_o(dbg_rise),
    .fall_o(dbg_fall)
  );
  assign dbg_chg = dbg_rise | dbg_fall;

  // supply, id open and id resistor changes share the request line with latch events; no debug
  // change touches the latch, so turning them on cannot disturb software polling
  wire supply_req;
  wire id_open_req;
  wire id_res_req;
  wire b_fall_req;
  wire b_rise_req;
  assign supply_req = dbg_chg[4] & extra_en[`UPES_XBIT_SUPPLY];
  assign id_open_req = dbg_chg[3] & extra_en[`UPES_XBIT_ID_OPEN];
  assign id_res_req = (|dbg_chg[2:0]) & extra_en[`UPES_XBIT_ID_RES];
  assign b_fall_req = dbg_fall[5] & extra_en[`UPES_XBIT_BSESS_FALL];
  assign b_rise_req = dbg_rise[5] & extra_en[`UPES_XBIT_BSESS_RISE];

  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      event_req_o <= 1'b0;
      alt_event_req_o <= 1'b0;
    end else begin
      event_req_o <= (|event_hit) | supply_req | id_open_req | id_res_req;
      alt_event_req_o <= b_fall_req | b_rise_req;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/upes_chk.sv
// checker: register port answers and event timing of the event block
// assumes one clock, reset synchronous and active low
`timescale 1ns/100ps
`default_nettype none
module upes_chk #(
  parameter [31:0] ID_SETTLE_CYCLES = 32'd20
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [5:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic session_end_i,
  input wire logic session_valid_i,
  input wire logic bus_power_valid_i,
  input wire logic [1:0] line_state_i,
  input wire logic low_power_i,
  input wire logic serial_mode_i,
  input wire logic carkit_mode_i,
  input wire logic [4:0] fall_event_enable_o,
  input wire logic event_req_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  // ****
  // properties
  // ****
  property p_rd;
    reg_rd_i |=> reg_rvalid_o;
  endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  property p_sts;
    reg_rd_i && reg_addr_i == 6'h13 |=> reg_rdata_o[7:5] == 3'h0 &&
      reg_rdata_o[3:1] == {$past(session_end_i), $past(session_valid_i),
      $past(bus_power_valid_i)};
  endproperty
  a_sts: assert property (p_sts) else $error("status wrong");
  property p_line;
    reg_rd_i && reg_addr_i == 6'h15 |=>
      reg_rdata_o == {6'h00, $past(line_state_i)};
  endproperty
  a_line: assert property (p_line) else $error("line view wrong");
  property p_fset;
    reg_wr_i && reg_addr_i == 6'h11 |=> fall_event_enable_o ==
      ($past(fall_event_enable_o) | $past(reg_wdata_i[4:0]));
  endproperty
  a_fset: assert property (p_fset) else $error("set alias wrong");
  property p_fclr;
    reg_wr_i && reg_addr_i == 6'h12 |=> fall_event_enable_o ==
      ($past(fall_event_enable_o) & ~$past(reg_wdata_i[4:0]));
  endproperty
  a_fclr: assert property (p_fclr) else $error("clear alias wrong");
  property p_frd;
    reg_rd_i && (reg_addr_i == 6'h11 || reg_addr_i == 6'h12) |=>
      reg_rdata_o == {3'h0, $past(fall_event_enable_o)};
  endproperty
  a_frd: assert property (p_frd) else $error("alias readback");
  property p_sefall;
    $fell(session_end_i) && fall_event_enable_o[3] && !reg_rd_i &&
      !low_power_i && !serial_mode_i && !carkit_mode_i |=> event_req_o;
  endproperty
  a_sefall: assert property (p_sefall) else $error("no fall event");
  property p_rst;
    $rose(rstn_i) |-> fall_event_enable_o == 5'h1f;
  endproperty
  a_rst: assert property (p_rst) else $error("enable reset");
endmodule
bind upes_event_regs upes_chk #(.ID_SETTLE_CYCLES(ID_SETTLE_CYCLES)) u_chk (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
  .session_end_i(session_end_i), .session_valid_i(session_valid_i),
  .bus_power_valid_i(bus_power_valid_i), .line_state_i(line_state_i),
  .low_power_i(low_power_i), .serial_mode_i(serial_mode_i),
  .carkit_mode_i(carkit_mode_i),
  .fall_event_enable_o(fall_event_enable_o), .event_req_o(event_req_o));
`default_nettype wire

// ===== testbench/upes_link_model.sv
// link model: issues register writes and reads on the port
// assumes every call starts at a falling edge of core_clk_i
`timescale 1ns/100ps
`default_nettype none
module upes_link_model (
  input wire logic core_clk_i,
  input wire logic [7:0] reg_rdata_i,
  input wire logic reg_rvalid_i,
  output logic [5:0] reg_addr_o,
  output logic reg_wr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_rd_o
);
  // ****
  // bus cycles
  // ****
  initial begin
    reg_addr_o = 6'h2a;
    reg_wr_o = 1'b0;
    reg_wdata_o = 8'h5a;
    reg_rd_o = 1'b0;
  end
  // idle address and data are inverted so stale values never look valid
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    reg_addr_o = a;
    reg_wdata_o = (a == 6'h3d) ? (d & 8'h7f) : d;
    reg_wr_o = 1'b1;
    @(negedge core_clk_i);
    reg_wr_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~reg_wdata_o;
    @(negedge core_clk_i);
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d,
                    output logic v);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge core_clk_i);
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    d = reg_rdata_i;
    v = reg_rvalid_i;
    @(negedge core_clk_i);
  endtask
endmodule
`default_nettype wire

// ===== testbench/tb.sv
// bench: table of register accesses, then event, mode and debug cases
// assumes the link model owns the register port
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin failures++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end
module tb;
  logic core_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [5:0] addr;
  logic wr, rd, rvalid, idsen = 1'b0, lp = 1'b0, bsv = 1'b0, req, alt;
  logic [7:0] wdata, rdata, d;
  logic v;
  logic [4:0] src = 5'h00, dbg = 5'h00, ren = 5'h1f, fen;
  logic [1:0] pd = 2'b11, md = 2'b00, ls = 2'b00, cn;
  int failures = 0, checks = 0, i;
  // row: write flag, address, write data, expected read
  logic [22:0] rows [0:11] = '{
    {1'b0, 6'h10, 8'h00, 8'h1f}, {1'b0, 6'h11, 8'h00, 8'h1f},
    {1'b1, 6'h12, 8'h04, 8'h1b}, {1'b1, 6'h11, 8'h04, 8'h1f},
    {1'b0, 6'h16, 8'h00, 8'h00}, {1'b1, 6'h17, 8'ha5, 8'ha5},
    {1'b1, 6'h18, 8'h05, 8'ha0}, {1'b1, 6'h16, 8'h3c, 8'h3c},
    {1'b0, 6'h3d, 8'h00, 8'h00}, {1'b1, 6'h3d, 8'h7c, 8'h7c},
    {1'b0, 6'h20, 8'h00, 8'h00}, {1'b0, 6'h14, 8'h00, 8'h00}};
  always #4 core_clk_i = ~core_clk_i;
  upes_link_model lnk (.core_clk_i(core_clk_i), .reg_rdata_i(rdata),
    .reg_rvalid_i(rvalid), .reg_addr_o(addr), .reg_wr_o(wr),
    .reg_wdata_o(wdata), .reg_rd_o(rd));
  upes_event_regs #(.ID_SETTLE_CYCLES(32'd20)) uut (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .id_grounded_i(src[4]),
    .session_end_i(src[3]), .session_valid_i(src[2]),
    .bus_power_valid_i(src[1]), .host_detach_i(src[0]),
    .rise_en_i(ren), .id_sense_enable_i(idsen),
    .pos_line_pulldown_en_i(pd[0]), .neg_line_pulldown_en_i(pd[1]),
    .low_power_i(lp), .serial_mode_i(md[0]), .carkit_mode_i(md[1]),
    .line_state_i(ls), .supply_monitor_ok_i(dbg[0]),
    .id_open_flag_i(dbg[1]), .id_resistor_cmp_a_i(dbg[2]),
    .id_resistor_cmp_b_i(dbg[3]), .id_resistor_cmp_c_i(dbg[4]),
    .b_session_valid_i(bsv), .fall_event_enable_o(fen),
    .event_req_o(req), .alt_event_req_o(alt));
  // ****
  // helpers
  // ****
  task automatic rdc(input logic [5:0] a, input logic [7:0] e);
    lnk.rd(a, d, v);
    `CHK("rvalid", 1'b1, v)
    `CHK("rdata", e, d)
  endtask
  // counts pulses of one request output over three cycles
  task automatic cnt(input logic s, input logic [1:0] x);
    cn = 2'd0;
    repeat (3) begin
      @(negedge core_clk_i);
      cn = cn + (s ? alt : req);
    end
    `CHK("req count", x, cn)
  endtask
  task wrap_up;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #200000;
    failures++;
    wrap_up;
  end
  // ****
  // sequence
  // ****
  initial begin
    repeat (8) @(negedge core_clk_i);
    rstn_i = 1'b1;
    `CHK("fall_en", 5'h1f, fen)
    for (i = 0; i < 12; i++) begin
      if (rows[i][22]) lnk.wr(rows[i][21:16], rows[i][15:8]);
      rdc(rows[i][21:16], rows[i][7:0]);
    end
    for (i = 0; i < 4; i++) begin
      ls = i[1:0];
      rdc(6'h15, {6'h00, i[1:0]});
    end
    src = 5'h1f;
    rdc(6'h13, 8'h0f);
    idsen = 1'b1;
    repeat (30) @(negedge core_clk_i);
    rdc(6'h13, 8'h1f);
    lnk.rd(6'h14, d, v);
    src[3] = 1'b0;
    cnt(1'b0, 2'd1);
    rdc(6'h14, 8'h08);
    rdc(6'h14, 8'h00);
    lnk.wr(6'h12, 8'h04);
    src[2] = 1'b0;
    cnt(1'b0, 2'd0);
    src[1] = 1'b0;
    rdc(6'h14, 8'h02);
    rdc(6'h14, 8'h00);
    for (i = 0; i < 2; i++) begin
      src[0] = ~src[0];
      @(negedge core_clk_i);
      md[i] = 1'b1;
      @(negedge core_clk_i);
      md[i] = 1'b0;
      rdc(6'h14, 8'h00);
    end
    src[4] = 1'b0;
    @(negedge core_clk_i);
    lp = 1'b1;
    @(negedge core_clk_i);
    rdc(6'h14, 8'h00);
    rdc(6'h13, 8'h00);
    lp = 1'b0;
    repeat (3) @(negedge core_clk_i);
    pd = 2'b01;
    src[0] = 1'b0;
    cnt(1'b0, 2'd0);
    for (i = 0; i < 5; i++) begin
      dbg[i] = ~dbg[i];
      cnt(1'b0, 2'd1);
    end
    bsv = 1'b1;
    cnt(1'b1, 2'd1);
    bsv = 1'b0;
    cnt(1'b1, 2'd1);
    lnk.wr(6'h3d, 8'h00);
    dbg[0] = ~dbg[0];
    cnt(1'b0, 2'd0);
    bsv = 1'b1;
    cnt(1'b1, 2'd0);
    src[4] = 1'b1;
    repeat (3) @(negedge core_clk_i);
    lnk.rd(6'h14, d, v);
    idsen = 1'b0;
    src[4] = 1'b0;
    cnt(1'b0, 2'd0);
    rdc(6'h13, 8'h10);
    idsen = 1'b1;
    cnt(1'b0, 2'd0);
    repeat (30) @(negedge core_clk_i);
    rdc(6'h14, 8'h10);
    ren[3] = 1'b0;
    src[3] = 1'b1;
    cnt(1'b0, 2'd0);
    rdc(6'h14, 8'h00);
    ren = 5'h1f;
    // mid-run reset: detached host and a high source held across it
    pd = 2'b11;
    src[0] = 1'b1;
    rstn_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    rstn_i = 1'b1;
    `CHK("fall_en", 5'h1f, fen)
    rdc(6'h14, 8'h01);
    rdc(6'h16, 8'h00);
    wrap_up;
  end
endmodule
`default_nettype wire
